// >>> hdl/dop_pkg.sv
package dop_pkg;
   // ************************************************************
   // Timing constants at a 200 MHz clock
   // ************************************************************
   localparam int unsigned CLK_MHZ          = 200;
   localparam int unsigned APERTURE_MS      = 3;
   localparam int unsigned BUSY_HIDC_MS     = 54;
   localparam int unsigned BUSY_LODC_MS     = 123;
   localparam int unsigned BUSY_KOHM_MS     = 73;
   localparam int unsigned BUSY_FILT_MS     = 523;
   localparam int unsigned RANGE_ADD_OUT_MS = 50;
   localparam int unsigned RANGE_ADD_IN_MS  = 280;
   localparam int unsigned MS_CYCLES        = CLK_MHZ * 1000;
   localparam int unsigned APERTURE_CYCLES  = APERTURE_MS * MS_CYCLES;

   // ************************************************************
   // Function codes and register layout
   // ************************************************************
   localparam logic [1:0] FUNC_VDC  = 2'h0;
   localparam logic [1:0] FUNC_VAC  = 2'h1;
   localparam logic [1:0] FUNC_OHM  = 2'h2;
   localparam logic [1:0] FUNC_KOHM = 2'h3;
   localparam logic [2:0] RANGE_LOW_LIMIT = 3'h3; // Codes 3..4 are the 1 V and 0.1 V ranges
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_MASK   = 4'h1;
   localparam logic [3:0] ADDR_FLAGS  = 4'h2;
   localparam logic [3:0] ADDR_CTRL   = 4'h3;
   localparam int unsigned IRQ_BITS   = 3;
   localparam int unsigned IRQ_READY  = 0;
   localparam int unsigned IRQ_OVLD   = 1;
   localparam int unsigned IRQ_APER   = 2;
   localparam logic [2:0] MASK_RESET  = 3'h0;
   localparam logic [1:0] CTRL_RESET  = 2'h0;
   localparam int unsigned CTRL_ADAPT = 0;
   localparam int unsigned CTRL_EXTTRIG = 1;

   typedef enum {ST_IDLE, ST_APER, ST_TIMEOUT} dop_state_type;
endpackage

// >>> hdl/dop_data_output_unit.sv
// Functional notes
// - Digits leave as 8-4-2-1 BCD by default.
// - Digit code passes through strap terminals.
// - Busy falls one cycle before valid data presented.
// - Aperture flag falls when sampling starts.
// - Aperture stays open three milliseconds.
// - Adaptive busy time by function, range, filter.
// - Trigger flag shows internal or external.
// - Group drives only while its inhibit high.
// - Outputs hold valid after busy falls.
// - Overload output separate from sequenced lines.
module dop_data_output_unit
   import dop_pkg::*;
#(
   parameter int unsigned DIGITS    = 5,
   parameter int unsigned APER_CYC  = APERTURE_CYCLES,
   parameter int unsigned MS_CYC    = MS_CYCLES
) (
   input  wire logic                clk,          // 200 MHz clock
   input  wire logic                rstn,         // Async reset, active low
   input  wire logic [3:0]          addr,         // Register address
   input  wire logic [31:0]         wrData,       // Register write data
   input  wire logic                wrStb,        // Write strobe
   input  wire logic                rdStb,        // Read strobe
   output logic [31:0]              rdData,       // Read data, cycle after strobe
   output logic                     irq,          // Level interrupt
   input  wire logic                extTrig,      // External trigger pulse
   input  wire logic                intTrig,      // Internal sample-rate trigger
   input  wire logic [4*DIGITS-1:0] measDigits,   // Converted BCD digits
   input  wire logic                measOvrng,    // Overrange from converter
   input  wire logic                measNeg,      // Negative polarity
   input  wire logic                measOvld,     // Overload detected
   input  wire logic [1:0]          measFunc,     // Function code
   input  wire logic [2:0]          measRange,    // Range code
   input  wire logic                filterIn,     // Filter switched in
   input  wire logic [3:0]          rangeSteps,   // Autorange changes this cycle
   input  wire logic [4*DIGITS-1:0] convIn,       // Return from conversion terminals
   output logic [4*DIGITS-1:0]      convOut,      // Drive to conversion terminals
   input  wire logic [DIGITS-1:0]   digitInhN,    // Decade gate, low inhibits
   input  wire logic                rangeInhN,    // Range gate
   input  wire logic                ovrInhN,      // Overrange gate
   input  wire logic                funcInhN,     // Primary function gate
   input  wire logic                secInhN,      // Secondary function gate
   input  wire logic                flagInhN,     // Flag gate
   output logic [4*DIGITS-1:0]      digitOut,     // Decade BCD outputs
   output logic [4*DIGITS-1:0]      digitOe,      // Decade output enables
   output logic [2:0]               rangeOut,     // Coded range
   output logic                     rangeOe,      // Range enable
   output logic                     ovrOut,       // Overrange bit
   output logic                     ovrOe,        // Overrange enable
   output logic [3:0]               funcOut,      // VDC VAC ohm kohm flags
   output logic                     funcOe,       // Function enable
   output logic                     polOut,       // Polarity, 1 = negative
   output logic                     filtOut,      // Filter flag
   output logic                     secOe,        // Secondary enable
   output logic                     busy,         // Data not ready
   output logic                     apertureN,    // Low while aperture open
   output logic                     trigFlag,     // Externally triggered
   output logic                     flagOe,       // Flag enable
   output logic                     overload      // Ungated overload
);

   // ************************************************************
   // Adaptive busy length in milliseconds
   // ************************************************************
   // 13 bits: filter in plus fifteen range changes overflows 12
   function automatic logic [12:0] busyMs(input logic [1:0] f, input logic [2:0] r,
                                          input logic filt, input logic [3:0] steps);
      logic [12:0] base;
      logic [12:0] add;
      base = 13'(BUSY_LODC_MS);
      add  = filt ? 13'(RANGE_ADD_IN_MS) : 13'(RANGE_ADD_OUT_MS);
      if (filt) begin
         base = 13'(BUSY_FILT_MS);
      end else if (f == FUNC_KOHM) begin
         base = 13'(BUSY_KOHM_MS);
      end else if (f == FUNC_VDC && r < RANGE_LOW_LIMIT) begin
         base = 13'(BUSY_HIDC_MS);
      end
      return 13'(base + add * 13'(steps));
   endfunction

   // ************************************************************
   // Measurement sequencer
   // ************************************************************
   dop_state_type state, next_state;
   logic [31:0]   cnt, next_cnt;
   logic [12:0]   msLeft, next_msLeft;
   logic          next_busy, next_apertureN, next_trigFlag;
   logic [1:0]    ctrl;
   logic          trigHit;
   logic          capture;

   assign trigHit = ctrl[CTRL_EXTTRIG] ? extTrig : intTrig;

   // Next state for sequencer
   always_comb begin
      next_state     = state;
      next_cnt       = cnt;
      next_msLeft    = msLeft;
      next_busy      = busy;
      next_apertureN = apertureN;
      next_trigFlag  = trigFlag;
      capture        = 1'b0;
      case (state)
         ST_IDLE: begin
            if (trigHit) begin
               next_state     = ST_APER;
               next_busy      = 1'b1;
               next_apertureN = 1'b0;
               next_trigFlag  = ctrl[CTRL_EXTTRIG];
               next_cnt       = 32'(APER_CYC - 1);
               next_msLeft    = busyMs(measFunc, measRange, filterIn, rangeSteps);
            end
         end
         ST_APER: begin
            if (cnt == 32'h0) begin
               next_apertureN = 1'b1;
               if (ctrl[CTRL_ADAPT]) begin
                  next_state = ST_TIMEOUT;
                  next_msLeft = (msLeft > 13'(APERTURE_MS)) ? 13'(msLeft - 13'(APERTURE_MS)) : 13'h0001;
                  next_cnt   = 32'(MS_CYC - 1);
               end else begin
                  next_state = ST_IDLE;
                  next_busy  = 1'b0;
                  capture    = 1'b1;
               end
            end else begin
               next_cnt = cnt - 32'h1;
            end
         end
         ST_TIMEOUT: begin
            if (cnt == 32'h0) begin
               next_cnt = 32'(MS_CYC - 1);
               if (msLeft <= 13'h0001) begin
                  next_state = ST_IDLE;
                  next_busy  = 1'b0;
                  capture    = 1'b1;
               end else begin
                  next_msLeft = msLeft - 13'h0001;
               end
            end else begin
               next_cnt = cnt - 32'h1;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state     <= ST_IDLE;
         cnt       <= 32'h0;
         msLeft    <= 13'h0000;
         busy      <= 1'b0;
         apertureN <= 1'b1;
         trigFlag  <= 1'b0;
      end else begin
         state     <= next_state;
         cnt       <= next_cnt;
         msLeft    <= next_msLeft;
         busy      <= next_busy;
         apertureN <= next_apertureN;
         trigFlag  <= next_trigFlag;
      end
   end

   // ************************************************************
   // Result latch and gated output drivers
   // ************************************************************
   logic [4*DIGITS-1:0] digLatch, next_digLatch;
   logic [2:0]          rngLatch, next_rngLatch;
   logic [1:0]          fnLatch, next_fnLatch;
   logic                ovrLatch, negLatch, filtLatch;
   logic                next_ovrLatch, next_negLatch, next_filtLatch;
   logic [4*DIGITS-1:0] next_digitOe;

   // Latch loads only at end of busy so data stays put while ready
   always_comb begin
      next_digLatch  = capture ? convIn : digLatch;
      next_rngLatch  = capture ? measRange : rngLatch;
      next_fnLatch   = capture ? measFunc : fnLatch;
      next_ovrLatch  = capture ? measOvrng : ovrLatch;
      next_negLatch  = capture ? measNeg : negLatch;
      next_filtLatch = capture ? filterIn : filtLatch;
   end

   // Per-decade enables follow each gate
   genvar g;
   generate
      for (g = 0; g < DIGITS; g++) begin : gDec
         assign next_digitOe[4*g+3:4*g] = {4{digitInhN[g]}};
      end
   endgenerate

   // Output registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         digLatch <= '0;
         rngLatch <= 3'h0;
         fnLatch  <= 2'h0;
         ovrLatch <= 1'b0;
         negLatch <= 1'b0;
         filtLatch <= 1'b0;
         convOut  <= '0;
         digitOut <= '0;
         digitOe  <= '0;
         rangeOut <= 3'h0;
         rangeOe  <= 1'b0;
         ovrOut   <= 1'b0;
         ovrOe    <= 1'b0;
         funcOut  <= 4'h0;
         funcOe   <= 1'b0;
         polOut   <= 1'b0;
         filtOut  <= 1'b0;
         secOe    <= 1'b0;
         flagOe   <= 1'b0;
         overload <= 1'b0;
      end else begin
         digLatch <= next_digLatch;
         rngLatch <= next_rngLatch;
         fnLatch  <= next_fnLatch;
         ovrLatch <= next_ovrLatch;
         negLatch <= next_negLatch;
         filtLatch <= next_filtLatch;
         convOut  <= measDigits;
         digitOut <= digLatch;
         digitOe  <= next_digitOe;
         rangeOut <= rngLatch;
         rangeOe  <= rangeInhN;
         ovrOut   <= ovrLatch;
         ovrOe    <= ovrInhN;
         funcOut  <= 4'h1 << fnLatch;
         funcOe   <= funcInhN;
         polOut   <= negLatch;
         filtOut  <= filtLatch;
         secOe    <= secInhN;
         flagOe   <= flagInhN;
         overload <= measOvld;
      end
   end

   // ************************************************************
   // Register port and interrupt
   // ************************************************************
   logic [IRQ_BITS-1:0] status, next_status, mask, next_mask;
   logic [1:0]          next_ctrl;
   logic [31:0]         next_rdData;
   logic [IRQ_BITS-1:0] events;
   logic                next_irq;

   assign events = {~next_apertureN & apertureN, measOvld & ~overload, capture};

   // Set wins over read-clear so no event is lost
   always_comb begin
      next_status = status;
      next_mask   = mask;
      next_ctrl   = ctrl;
      next_rdData = 32'h0;
      if (rdStb) begin
         case (addr)
            ADDR_STATUS: begin
               next_rdData = 32'(status);
               next_status = '0;
            end
            ADDR_MASK:  next_rdData = 32'(mask);
            ADDR_FLAGS: next_rdData = {26'h0, state != ST_IDLE, trigFlag, overload, ~apertureN, busy, 1'b0};
            ADDR_CTRL:  next_rdData = 32'(ctrl);
            default:    next_rdData = 32'h0;
         endcase
      end
      if (wrStb) begin
         case (addr)
            ADDR_MASK: next_mask = wrData[IRQ_BITS-1:0];
            ADDR_CTRL: next_ctrl = wrData[1:0];
            default:   next_ctrl = ctrl;
         endcase
      end
      next_status = next_status | events;
      next_irq    = |(next_status & next_mask);
   end

   // Register file flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status <= '0;
         mask   <= MASK_RESET;
         ctrl   <= CTRL_RESET;
         rdData <= 32'h0;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         mask   <= next_mask;
         ctrl   <= next_ctrl;
         rdData <= next_rdData;
         irq    <= next_irq;
      end
   end

endmodule // dop_data_output_unit

// >>> testbench/dop_checker_props.sv
// ************************************************************
// Port checker for the data output unit
// ************************************************************
module dop_checker #(
   parameter int unsigned DIGITS   = 5,  // Decades
   parameter int unsigned APER_CYC = 20  // Aperture cycles
) (
   input wire logic                clk,        // Clock
   input wire logic                rstn,       // Async reset, active low
   input wire logic                rdStb,      // Read strobe
   input wire logic [31:0]         rdData,     // Read data
   input wire logic [4*DIGITS-1:0] measDigits, // Converter digits
   input wire logic [4*DIGITS-1:0] convOut,    // Strap drive
   input wire logic [DIGITS-1:0]   digitInhN,  // Decade gates
   input wire logic [4*DIGITS-1:0] digitOe,    // Decade enables
   input wire logic [4*DIGITS-1:0] digitOut,   // Decade outputs
   input wire logic                ovrOut,     // Overrange
   input wire logic                polOut,     // Polarity
   input wire logic                busy,       // Data not ready
   input wire logic                apertureN   // Low while sampling
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [4*DIGITS-1:0] gateX;
   logic [31:0]         aperCnt;
   // Gate per bit, so one nibble check covers all four lines
   always_comb begin
      for (int g = 0; g < DIGITS; g++) gateX[4*g+:4] = {4{digitInhN[g]}};
   end
   // Aperture length, counted rather than unrolled
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) aperCnt <= 32'h0;
      else aperCnt <= apertureN ? 32'h0 : aperCnt + 32'h1;
   end
   // Measurement steps
   sequence apOpen;
      $fell(apertureN);
   endsequence
   sequence busyRun;
      (busy && !apertureN) [*8];
   endsequence
   AST_RD_IDLE: assert property (!$past(rdStb) |-> rdData == 32'h0)
      else $error("Read data not zero outside read answer");
   AST_CONV_PATH: assert property ($past(rstn) |-> convOut == $past(measDigits))
      else $error("Strap drive does not follow digits");
   AST_GATE_DIGITS: assert property ($past(rstn) |-> digitOe == $past(gateX))
      else $error("Decade enable not following its gate");
   AST_APER_BUSY: assert property (apOpen |-> busy)
      else $error("Aperture opened without busy");
   AST_APER_LEN: assert property ($rose(apertureN) |-> aperCnt == APER_CYC)
      else $error("Aperture length wrong");
   AST_BUSY_MIN: assert property ($rose(busy) |-> busyRun)
      else $error("Busy dropped inside aperture");
   AST_READY_CLOSED: assert property ($fell(busy) |-> apertureN)
      else $error("Ready while aperture open");
   AST_DATA_HOLD: assert property ($past(rstn) && !$past(busy, 2) && !$past(busy)
      |-> $stable({digitOut, ovrOut, polOut}))
      else $error("Data changed while ready");
endmodule // dop_checker

bind dop_data_output_unit dop_checker #(.DIGITS(DIGITS), .APER_CYC(APER_CYC)) dop_checker_i (.clk, .rstn,
   .rdStb, .rdData, .measDigits, .convOut, .digitInhN, .digitOe, .digitOut, .ovrOut, .polOut, .busy, .apertureN);

// >>> testbench/dop_ring_model.sv
// ************************************************************
// Nine-segment ring sequencer on the far side
// ************************************************************
module dop_ring_model (
   input  wire logic       clk,   // Bench clock
   input  wire logic       rstn,  // Async reset, active low
   input  wire logic       busy,  // Data not ready
   input  wire logic       seqEn, // Sequenced mode, else gates open
   output logic      [8:0] inhN,  // One gate per segment
   output logic            adv    // Step sync pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] seg;
   logic [1:0] cnt;
   logic       busyD;
   // Open gates float high; an idle ring holds every group off
   assign inhN = !seqEn ? 9'h1FF : (seg < 4'h9 ? 9'h001 << seg : 9'h000);
   // Four cycles a segment, sync late so enables have settled
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         seg <= 4'h9;
         cnt <= 2'h0;
         busyD <= 1'b0;
         adv <= 1'b0;
      end else begin
         busyD <= busy;
         adv <= (seg < 4'h9) && (cnt == 2'h1);
         cnt <= cnt + 2'h1;
         if (busyD && !busy && seqEn) begin
            seg <= 4'h0;
            cnt <= 2'h0;
         end else if (seg < 4'h9 && cnt == 2'h3) begin
            seg <= seg + 4'h1;
         end
      end
   end
endmodule // dop_ring_model

// >>> testbench/dop_data_output_unit_tb.sv
module dop_data_output_unit_tb
   import dop_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned DG = 5;
   localparam int unsigned AC = APERTURE_MS * 10; // Aperture is 3 ms of MC cycles, else adaptive time drifts
   localparam int unsigned MC = 10;
   logic        clk = 1'b0, rstn = 1'b0, wrStb = 1'b0, rdStb = 1'b0, rdP = 1'b0, extTrig = 1'b0;
   logic        intTrig = 1'b0, measOvrng = 1'b0, measNeg = 1'b0, measOvld = 1'b0, filterIn = 1'b0;
   logic        net = 1'b0, seqEn = 1'b1, irq, rangeOe, ovrOut, ovrOe, funcOe, polOut, filtOut, secOe;
   logic        busy, apertureN, trigFlag, flagOe, overload, adv;
   logic        apD = 1'b1;
   int          shot = 0;
   logic [3:0]  addr = 4'h0, rangeSteps = 4'h0, bus, funcOut;
   logic [31:0] wrData = 32'h0, rdData;
   logic [19:0] measDigits = 20'h0, convIn, convOut, digitOut, digitOe;
   logic [1:0]  measFunc = 2'h0;
   logic [2:0]  measRange = 3'h0, rangeOut, msk = 3'h0;
   logic [8:0]  inhN;
   logic [3:0]  bq[$];
   logic [31:0] rq[$];
   int          nErrors = 0, checkCount = 0;
   dop_data_output_unit #(.DIGITS(DG), .APER_CYC(AC), .MS_CYC(MC)) dop_data_output_unit_i (
      .clk, .rstn, .addr, .wrData, .wrStb, .rdStb, .rdData, .irq, .extTrig, .intTrig, .measDigits,
      .measOvrng, .measNeg, .measOvld, .measFunc, .measRange, .filterIn, .rangeSteps, .convIn, .convOut,
      .digitInhN(inhN[4:0]), .rangeInhN(inhN[5]), .ovrInhN(inhN[6]), .funcInhN(inhN[7]), .secInhN(inhN[8]),
      .flagInhN(!seqEn), .digitOut, .digitOe, .rangeOut, .rangeOe, .ovrOut, .ovrOe, .funcOut, .funcOe,
      .polOut, .filtOut, .secOe, .busy, .apertureN, .trigFlag, .flagOe, .overload);
   dop_ring_model dop_ring_model_i (.clk, .rstn, .busy, .seqEn, .inhN, .adv);
   always #2.5 clk = ~clk;
   // Straps or an excess-3 network; shared lines pulled low when undriven
   always_comb begin
      bus = ({1'b0, rangeOut} & {4{rangeOe}}) | {3'h0, ovrOut & ovrOe} | (funcOut & {4{funcOe}});
      bus = bus | ({2'h0, polOut, filtOut} & {4{secOe}});
      for (int g = 0; g < DG; g++) begin
         convIn[4*g+:4] = convOut[4*g+:4] + (net ? 4'h3 : 4'h0);
         bus = bus | (digitOut[4*g+:4] & digitOe[4*g+:4]);
      end
   end
   // ************************************************************
   // Bus tasks and result checking
   // ************************************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] e);
      checkCount++;
      if (got !== e) begin
         nErrors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, e);
      end
   endtask
   task automatic finalReport();
      $display("Checks %0d, errors %0d", checkCount, nErrors);
      if (nErrors == 0 && checkCount > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic fail();
      nErrors++;
      finalReport();
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      {addr, wrData, wrStb} <= {a, d, 1'b1};
      @(posedge clk);
      wrStb <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk);
      {addr, rdStb} <= {a, 1'b1};
      rq.push_back(e);
      @(posedge clk);
      rdStb <= 1'b0;
   endtask
   // Oldest note against each read answer and each sequenced character
   always @(posedge clk) begin
      rdP <= rdStb;
      if (rdP) cmp(rdData, rq.pop_front());
      if (adv) cmp(32'(bus), 32'(bq.pop_front()));
   end
   // Far one-shot from the last aperture leading edge; input may switch once it expires
   always @(posedge clk) begin
      apD <= apertureN;
      if (apD && !apertureN) shot <= AC;
      else if (shot > 0) shot <= shot - 1;
      if (shot == 1) cmp(32'(apertureN), 32'h1);
   end
   // One measurement; busy time worked out from the adaptive table
   task automatic meas(input logic ad, ex, input logic [1:0] fn, input logic [2:0] rg, input logic fl,
                       input logic [3:0] st, input logic nt, sq, ov);
      logic [19:0] d, e;
      logic [31:0] ms, n;
      logic [1:0]  pr;
      int          i;
      pr = 2'($urandom);
      for (i = 0; i < DG; i++) d[4*i+:4] = 4'($urandom % 10);
      for (i = 0; i < DG; i++) e[4*i+:4] = d[4*i+:4] + (nt ? 4'h3 : 4'h0);
      ms = fl ? BUSY_FILT_MS + RANGE_ADD_IN_MS * st : RANGE_ADD_OUT_MS * st + (fn == FUNC_KOHM ? BUSY_KOHM_MS
         : (fn == FUNC_VDC && rg < RANGE_LOW_LIMIT) ? BUSY_HIDC_MS : BUSY_LODC_MS);
      if (sq) begin
         for (i = 0; i < DG; i++) bq.push_back(e[4*i+:4]);
         bq.push_back({1'b0, rg});
         bq.push_back({3'h0, pr[0]});
         bq.push_back(4'h1 << fn);
         bq.push_back({2'h0, pr[1], fl});
      end
      wr(ADDR_CTRL, {30'h0, ex, ad});
      @(posedge clk);
      {measDigits, measFunc, measRange, filterIn, rangeSteps, measOvld} <= {d, fn, rg, fl, st, ov};
      {measNeg, measOvrng, net, seqEn} <= {pr, nt, sq};
      @(posedge clk);
      {extTrig, intTrig} <= ex ? 2'h2 : 2'h1;
      @(posedge clk);
      {extTrig, intTrig} <= 2'h0;
      for (i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
      if (busy !== 1'b1) fail();
      n = 32'h0;
      for (i = 0; i < 20000 && busy === 1'b1; i++) begin
         @(posedge clk);
         n++;
      end
      cmp(n, ad ? ms * MC : AC);
      repeat (2) @(posedge clk);
      cmp(32'(trigFlag), 32'(ex));
      cmp(32'(overload), 32'(ov));
      cmp(32'(flagOe), 32'(!sq));
      if (!sq) cmp(32'(digitOut & digitOe), 32'(e));
      for (i = 0; i < 300 && bq.size() > 0; i++) @(posedge clk);
      if (bq.size() > 0) fail();
      cmp(32'(irq), 32'(|({1'b1, ov, 1'b1} & msk)));
      rd(ADDR_STATUS, {29'h0, 1'b1, ov, 1'b1});
      rd(ADDR_STATUS, 32'h0);
      rd(ADDR_FLAGS, {26'h0, 1'b0, ex, ov, 3'h0});
      repeat (3) @(posedge clk);
      cmp(32'(irq), 32'h0);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      void'($urandom(32'hE7FF));
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd(ADDR_CTRL, 32'(CTRL_RESET));
      rd(ADDR_MASK, 32'(MASK_RESET));
      wr(4'hF, 32'hFFFFFFFF);
      rd(4'hF, 32'h0);
      msk = 3'h1 << IRQ_READY;
      wr(ADDR_MASK, 32'(msk));
      rd(ADDR_MASK, 32'(msk));
      meas(1'b0, 1'b0, FUNC_VDC, 3'h0, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0);
      meas(1'b1, 1'b0, FUNC_VDC, 3'h2, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0);
      meas(1'b1, 1'b0, FUNC_VDC, 3'h3, 1'b0, 4'h0, 1'b1, 1'b1, 1'b0);
      meas(1'b1, 1'b1, FUNC_VAC, 3'h2, 1'b0, 4'h1, 1'b0, 1'b1, 1'b1);
      meas(1'b1, 1'b0, FUNC_OHM, 3'h5, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0);
      meas(1'b1, 1'b0, FUNC_KOHM, 3'h1, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0);
      msk = 3'h0;
      wr(ADDR_MASK, 32'h0);
      meas(1'b1, 1'b0, FUNC_VDC, 3'h0, 1'b1, 4'h1, 1'b0, 1'b1, 1'b0);
      // Mid-run reset must bring mask and control back
      wr(ADDR_MASK, 32'h7);
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd(ADDR_MASK, 32'(MASK_RESET));
      rd(ADDR_CTRL, 32'(CTRL_RESET));
      repeat (4) @(posedge clk);
      finalReport();
   end
endmodule // dop_data_output_unit_tb
